// ===== rtl/drst_map.svh
// timing counts, option codes and edge codes for the drive reset input logic
`ifndef DRST_MAP_SVH
`define DRST_MAP_SVH
`define DRST_CLK_MHZ        200
`define DRST_MIN_PULSE_MS   12
`define DRST_ALARM_MAX_MS   30
`define DRST_PANEL_HOLD_MS  4000
`define DRST_MIN_PULSE_CYC  (`DRST_MIN_PULSE_MS * 1000 * `DRST_CLK_MHZ)
`define DRST_ALARM_MAX_CYC  (`DRST_ALARM_MAX_MS * 1000 * `DRST_CLK_MHZ)
`define DRST_PANEL_HOLD_CYC (`DRST_PANEL_HOLD_MS * 1000 * `DRST_CLK_MHZ)
`define DRST_FUNC_RESET     8'h12
`define DRST_FUNC_W         8
`define DRST_NUM_INPUTS     5
`define DRST_EDGE_LEADING   1'b0
`define DRST_EDGE_TRAILING  1'b1
`endif

// ===== rtl/drst_pkg.sv
// types shared by the drive reset input logic
`default_nettype none
package drst_pkg;
  typedef logic [7:0] drst_func_t;
  typedef enum logic {
    DRST_EDGE_LEAD,
    DRST_EDGE_TRAIL
  } drst_edge_t;
endpackage
`default_nettype wire

// ===== rtl/drst_filter.sv
// synchroniser and minimum-width filter for the reset input
`default_nettype none
module drst_filter #(
  parameter int unsigned MIN_CYC = 2400000
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic raw_in,
  output logic      clean_q
);
  localparam int unsigned CW = $clog2(MIN_CYC + 1);
  logic          s1_q;
  logic          s2_q;
  logic [CW-1:0] cnt_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end

  // a change is accepted only once it has held the full minimum width
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q   <= '0;
      clean_q <= 1'b0;
    end else if (s2_q == clean_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= CW'(MIN_CYC - 1)) begin
      cnt_q   <= '0;
      clean_q <= s2_q;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/drst_core.sv
// reset input handling: terminal selection, edge choice, trip/alarm clear, panel fault
`default_nettype none
`include "drst_map.svh"
// Notes on behaviour
// - reset fires on a full on-off pulse only with trailing edge select
// - reset clears trip state
// - alarm output cleared within 30 ms
// - while active: output off, trip cleared, reset
// - any of five inputs, function code 18
// - edge select picks leading or trailing edge
// - reset input only normally-open polarity
// - power-up performs the same reset
// - active over 4 s from power-up: panel fault
// - panel fault clears after off and key
// - run still active restarts motor after reset
module drst_core
  import drst_pkg::*;
#(
  parameter int unsigned MIN_PULSE_CYC  = `DRST_MIN_PULSE_CYC,
  parameter int unsigned PANEL_HOLD_CYC = `DRST_PANEL_HOLD_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [4:0]        input_terminals,
  input  wire logic [4:0]        input_nc_select,
  input  wire drst_pkg::drst_func_t input1_function_select,
  input  wire drst_pkg::drst_func_t input2_function_select,
  input  wire drst_pkg::drst_func_t input3_function_select,
  input  wire drst_pkg::drst_func_t input4_function_select,
  input  wire drst_pkg::drst_func_t input5_function_select,
  input  wire drst_pkg::drst_edge_t reset_edge_select,
  // drive state and operator panel
  input  wire logic              trip_event,
  input  wire logic              run_command,
  input  wire logic              operator_key,
  // outputs; data outputs all come from flip-flops
  output logic                   reset_input_terminal,
  output logic                   trip_q,
  output logic                   alarm_out_q,
  output logic                   motor_enable_q,
  output logic                   drive_reset_pulse_q,
  output logic                   remote_panel_link_fault_message
);
  import drst_pkg::*;

  localparam int unsigned HW        = $clog2(PANEL_HOLD_CYC + 1);
  // alarm bound counted from the raw onset, whatever the filter length
  localparam int unsigned ALARM_CYC = `DRST_ALARM_MAX_CYC;
  localparam int unsigned AW        = $clog2(ALARM_CYC + 1);

  logic [4:0]    sel_mask;
  drst_func_t    fsel [5];
  logic          raw_sel;
  logic          filt;

  logic          filt_prev_q;
  logic          por_q;
  logic          fire;
  logic          trip_clear;
  logic          motor_block;

  logic          panel_q;
  logic          hold_arm_q;
  logic [HW-1:0] hold_cnt_q;
  logic [AW-1:0] onset_cnt_q;
  logic          alarm_block_q;

  // option code that assigns the reset function
  function automatic logic is_reset_fn(input drst_func_t f);
    return f == drst_func_t'(`DRST_FUNC_RESET);
  endfunction

  // function codes per terminal, indexed for the loop
  always_comb begin
    fsel[0] = input1_function_select;
    fsel[1] = input2_function_select;
    fsel[2] = input3_function_select;
    fsel[3] = input4_function_select;
    fsel[4] = input5_function_select;
    sel_mask = '0;
    for (int i = 0; i < 5; i++) begin
      sel_mask[i] = is_reset_fn(fsel[i]);
    end
  end

  // any terminal carrying reset asserts it; the nc option has no say here
  assign raw_sel = |(sel_mask & input_terminals);
  assign reset_input_terminal = filt;

  drst_filter #(
    .MIN_CYC (MIN_PULSE_CYC)
  ) u_filter (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .raw_in  (raw_sel),
    .clean_q (filt)
  );

  // edge choice; with trailing edge the full on-off pulse is needed
  always_comb begin
    if (reset_edge_select == DRST_EDGE_TRAIL) begin
      fire = filt_prev_q & ~filt;
    end else begin
      fire = filt & ~filt_prev_q;
    end
  end

  // power-up marker, high in the first cycle after reset only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      por_q <= 1'b1;
    end else begin
      por_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      filt_prev_q <= 1'b0;
    end else begin
      filt_prev_q <= filt;
    end
  end

  // one-cycle reset strobe, also issued once after power-up
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      drive_reset_pulse_q <= 1'b0;
    end else begin
      drive_reset_pulse_q <= fire | por_q;
    end
  end

  // reset level clears trip as well as the chosen edge
  assign trip_clear = fire | filt;

  // trip cleared by reset; a new trip in the same cycle wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      trip_q <= 1'b0;
    end else if (trip_event) begin
      trip_q <= 1'b1;
    end else if (trip_clear) begin
      trip_q <= 1'b0;
    end
  end

  // hard bound: alarm forced off before the limit even if the filter were longer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      onset_cnt_q <= '0;
    end else if (!raw_sel) begin
      onset_cnt_q <= '0;
    end else if (onset_cnt_q < AW'(ALARM_CYC - 2)) begin
      onset_cnt_q <= onset_cnt_q + AW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_block_q <= 1'b0;
    end else begin
      alarm_block_q <= raw_sel & (onset_cnt_q >= AW'(ALARM_CYC - 2));
    end
  end

  // alarm follows trip with one cycle lag, well inside 30 ms
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_out_q <= 1'b0;
    end else begin
      alarm_out_q <= trip_q & ~filt & ~fire & ~alarm_block_q;
    end
  end

  // everything that must hold the output off this cycle
  assign motor_block = filt | trip_q | trip_event | por_q;

  // output off while reset active or tripped; restarts at once if run held
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      motor_enable_q <= 1'b0;
    end else begin
      motor_enable_q <= run_command & ~motor_block;
    end
  end

  // watch arms at reset, drops at the first release or when it expires
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hold_arm_q <= 1'b1;
    end else if (hold_arm_q && (!raw_sel || hold_cnt_q >= HW'(PANEL_HOLD_CYC))) begin
      hold_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_q <= '0;
    end else if (hold_arm_q && raw_sel && hold_cnt_q < HW'(PANEL_HOLD_CYC)) begin
      hold_cnt_q <= hold_cnt_q + HW'(1);
    end
  end

  // panel fault: display only, the drive itself keeps no fault
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      panel_q <= 1'b0;
    end else if (hold_arm_q && raw_sel && hold_cnt_q >= HW'(PANEL_HOLD_CYC)) begin
      panel_q <= 1'b1;
    end else if (panel_q && !filt && !raw_sel && operator_key) begin
      panel_q <= 1'b0;
    end
  end
  assign remote_panel_link_fault_message = panel_q;

endmodule
`default_nettype wire

// ===== tb/drst_contact.sv
// contact model driving the reset terminal
`default_nettype none
module drst_contact (
  input  wire logic sys_clk,
  output logic      term
);
  timeunit 1ns;
  timeprecision 1ps;
  // open contact reads low, as with a pull-down
  initial term = 1'b0;
  task automatic press(input int n);
    @(posedge sys_clk) #1 term = 1'b1;
    repeat (n) @(posedge sys_clk);
    #1 term = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/drst_core_chk.sv
// port assertions for the drive reset input logic
`default_nettype none
module drst_core_chk
  import drst_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 nrst,
  input wire logic                 reset_input_terminal,
  input wire logic                 run_command,
  input wire logic                 trip_event,
  input wire logic                 trip_q,
  input wire logic                 alarm_out_q,
  input wire logic                 motor_enable_q,
  input wire logic                 drive_reset_pulse_q,
  input wire logic                 operator_key,
  input wire logic                 remote_panel_link_fault_message,
  input wire drst_pkg::drst_edge_t reset_edge_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence rise_s; $rose(reset_input_terminal); endsequence
  sequence fall_s; $fell(reset_input_terminal); endsequence
  strobe_width_a:
    assert property (drive_reset_pulse_q |=> !drive_reset_pulse_q) else $error("strobe width");
  trip_clear_a:
    assert property (reset_input_terminal && !trip_event |=> !trip_q) else $error("trip kept");
  alarm_clear_a:
    assert property (reset_input_terminal |=> !alarm_out_q) else $error("alarm kept");
  motor_off_a:
    assert property (reset_input_terminal |=> !motor_enable_q) else $error("motor on");
  power_up_a:
    assert property (!$past(nrst) |=> drive_reset_pulse_q) else $error("no power-up strobe");
  lead_strobe_a:
    assert property ((reset_edge_select == DRST_EDGE_LEAD) ##0 rise_s |-> ##[1:2]
      drive_reset_pulse_q) else $error("no leading strobe");
  trail_strobe_a:
    assert property ((reset_edge_select == DRST_EDGE_TRAIL) ##0 fall_s |-> ##[1:2]
      drive_reset_pulse_q) else $error("no trailing strobe");
  motor_restart_a:
    assert property (fall_s ##0 run_command |-> ##[1:3] motor_enable_q) else $error("no restart");
  fault_hold_a:
    assert property (remote_panel_link_fault_message && !operator_key |=>
      remote_panel_link_fault_message) else $error("fault dropped");
endmodule
bind drst_core drst_core_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .trip_q(trip_q),
  .reset_input_terminal(reset_input_terminal), .run_command(run_command),
  .trip_event(trip_event), .alarm_out_q(alarm_out_q), .motor_enable_q(motor_enable_q),
  .drive_reset_pulse_q(drive_reset_pulse_q), .operator_key(operator_key),
  .remote_panel_link_fault_message(remote_panel_link_fault_message),
  .reset_edge_select(reset_edge_select));
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the drive reset input logic
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import drst_pkg::*;
  logic sys_clk = 0, nrst = 0, trip_ev = 0, run = 0, key = 0, term, trip, alarm, motor, stb, flt;
  logic rin;
  logic [4:0] nc = 5'h00;
  drst_func_t fs [5];
  drst_edge_t es = DRST_EDGE_LEAD;
  int miscompares = 0, checks_done = 0, strobes = 0, k = 0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (stb === 1'b1) strobes++;
  drst_contact pm (.sys_clk(sys_clk), .term(term));
  // short counts keep the run brief; expectations follow them
  drst_core #(.MIN_PULSE_CYC(8), .PANEL_HOLD_CYC(20)) uut (.sys_clk(sys_clk), .nrst(nrst),
    .input_terminals({4'h0, term} << k), .input_nc_select(nc),
    .input1_function_select(fs[0]), .input2_function_select(fs[1]),
    .input3_function_select(fs[2]), .input4_function_select(fs[3]),
    .input5_function_select(fs[4]), .reset_edge_select(es), .trip_event(trip_ev),
    .run_command(run), .operator_key(key), .reset_input_terminal(rin), .trip_q(trip),
    .alarm_out_q(alarm), .motor_enable_q(motor), .drive_reset_pulse_q(stb),
    .remote_panel_link_fault_message(flt));
  task automatic chk(input string nm, input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run;
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    foreach (fs[i]) fs[i] = (i == 0) ? 8'h12 : 8'h00;
    fork pm.press(60); join_none
    cyc(16);
    nrst = 1'b1;
    cyc(2);
    chk("power-up strobe", strobes == 1, 1'b1);
    cyc(40);
    chk("panel fault", flt, 1'b1);
    chk("trip", trip, 1'b0);
    cyc(30);
    chk("panel fault kept", flt, 1'b1);
    key = 1'b1;
    cyc(1);
    key = 1'b0;
    cyc(2);
    chk("panel fault cleared", flt, 1'b0);
    nc = 5'h1f;
    for (k = 0; k < 5; k++) begin
      foreach (fs[i]) fs[i] = (i == k) ? 8'h12 : 8'h00;
      es = drst_edge_t'(k[0]);
      trip_ev = 1'b1;
      cyc(1);
      trip_ev = 1'b0;
      cyc(2);
      chk("trip set", trip, 1'b1);
      chk("alarm set", alarm, 1'b1);
      pm.press(3);
      cyc(20);
      chk("glitch ignored", trip, 1'b1);
      chk("glitch level", rin, 1'b0);
      strobes = 0;
      run = 1'b1;
      pm.press(12);
      chk("filtered level", rin, 1'b1);
      chk("trip cleared", trip, 1'b0);
      chk("alarm cleared", alarm, 1'b0);
      chk("motor off", motor, 1'b0);
      cyc(15);
      chk("one strobe", strobes == 1, 1'b1);
      chk("motor restart", motor, 1'b1);
      pm.press(12);
      chk("motor off untripped", motor, 1'b0);
      run = 1'b0;
      cyc(15);
    end
    complete_run();
  end
  initial begin
    #20000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
